/* File: design/cmc_consts.vh */
// Constants for the module configuration block of a bus controller.
// Assumes inclusion by bare name from the design folder.
`ifndef CMC_CONSTS_VH
`define CMC_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses on the host bus)
`define CMC_OFF_MCR 8'h00
`define CMC_OFF_ERRCNT 8'h26

// ==========================================================
// Field positions of module_config_register
`define CMC_B_STOP 15
`define CMC_B_SUSP_EN 14
`define CMC_B_SPARE_SUSP 13
`define CMC_B_HALT 12
`define CMC_B_NOT_SYNCED 11
`define CMC_B_WAKE_IE 10
`define CMC_B_SOFT_RST 9
`define CMC_B_DBG_ENTERED 8
`define CMC_B_SUPERVISOR_ONLY_SELECT_ONLY 7
`define CMC_B_SELF_WAKE 6
`define CMC_B_AUTO_PSAVE 5
`define CMC_B_STOPPED 4
`define CMC_ARB_HI 3
`define CMC_ARB_LO 0

// ==========================================================
// Reset values and counts
`define CMC_MCR_RESET 16'h5980
`define CMC_RO_MASK 16'h0b10
`define CMC_SYNC_BITS 4'hb
`define CMC_SYNC_W 4
`define CMC_CNT_W 8
`define CMC_ZERO16 16'h0000
`define CMC_ZERO8 8'h00

`endif

/* File: design/cmc_module_config.v */
// Module configuration register and mode control of a bus controller.
// Assumes synchronous host bus: sel/wr strobes for one cycle, space code
// bit high for supervisor accesses, bus pins sampled synchronously.
//
// Behaviour
// - Suspend disabled ignores suspend input and halt
// - Debug entered when enabled and suspend or halt
// - Clearing suspend enable leaves debug mode
// - Spare suspend enable bit has no effect
// - Halt resets to one, software clears it
// - Error counters host-writable only while halt set
// - Not-synced set on entry, cleared only on sync into run mode
// - Wake interrupt only when enable bit set
// - Soft reset clears core state and configuration
// - Soft reset spares bus control, divider, buffers
// - Soft reset also clears the stop bit
// - Soft reset bit clears itself
// - Debug-entered clears once prescaler runs again
// - Supervisor-only mode withholds acknowledge for user
// - Unrestricted mode also acks user counter access; user supervisor-reg unimplemented
// - Self-wake clears stop on recessive-to-dominant edge
// - Auto power save gates clocks when idle
// - Host clocks stay running; independent of wake bits
// - Stopped flag follows clock shutdown and restart
// - Four-bit arbitration id, resets zero, modular only
// - Stop bit shuts clocks; cleared by host/self-wake
`timescale 1ns/100ps
`default_nettype none
`include "cmc_consts.vh"

module cmc_module_config #(
  parameter CNT_W = `CMC_CNT_W
) (
  input wire core_clk,
  input wire rst,
  // Host bus
  input wire host_sel,
  input wire host_wr,
  input wire [7:0] host_addr,
  input wire [15:0] host_wdata,
  input wire space_code_bit,
  output reg [15:0] host_rdata,
  output wire slave_acknowledge,
  output wire unimplemented_access,
  // System and bus side
  input wire debug_suspend,
  input wire bus_rx_recessive,
  input wire bit_tick,
  input wire core_busy,
  input wire interrupt_style_select,
  input wire [CNT_W-1:0] rx_err_count,
  input wire [CNT_W-1:0] tx_err_count,
  // Controls to the rest of the controller
  output wire err_count_write,
  output wire [CNT_W-1:0] err_count_wdata_rx,
  output wire [CNT_W-1:0] err_count_wdata_tx,
  output reg soft_reset_pulse,
  output wire core_clk_enable,
  output wire host_clk_enable,
  output wire prescaler_run,
  output reg wake_interrupt,
  output wire [3:0] arbitration_id_out,
  output wire arbitration_active
);

  // ==========================================================
  // Mode state
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_DEBUG = 4'h2;
  localparam [3:0] ST_STOP = 4'h4;
  localparam [3:0] ST_SYNC = 4'h8;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [15:0] module_configuration;
  reg not_synced;
  reg dbg_entered;
  reg stopped;
  reg wake_armed;
  reg bus_prev;
  wire synced;
  wire sync_clear;

  wire stop_bit = module_configuration[`CMC_B_STOP];
  wire susp_en = module_configuration[`CMC_B_SUSP_EN];
  wire halt_bit = module_configuration[`CMC_B_HALT];
  wire supervisor_only_select_only = module_configuration[`CMC_B_SUPERVISOR_ONLY_SELECT_ONLY];

  // Spare suspend enable is stored but never read by the mode logic
  wire debug_req = susp_en && (debug_suspend || halt_bit);

  // ==========================================================
  // Host decode
  function is_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      is_hit = (addr == off);
    end
  endfunction

  wire user_acc = !space_code_bit;
  wire hit_mcr = is_hit(host_addr, `CMC_OFF_MCR);
  wire hit_err = is_hit(host_addr, `CMC_OFF_ERRCNT);
  // Configuration register is always supervisor space; error counters are assignable
  wire ack_mcr = hit_mcr && !user_acc;
  wire ack_err = hit_err && !(supervisor_only_select_only && user_acc);
  wire any_hit = hit_mcr || hit_err;
  assign slave_acknowledge = host_sel && (ack_mcr || (hit_err && ack_err));
  // User cycles withheld in supervisor-only mode run externally, so not flagged here
  assign unimplemented_access = host_sel && !supervisor_only_select_only && user_acc &&
                                (hit_mcr || !any_hit);

  wire mcr_write = host_sel && host_wr && ack_mcr;
  assign err_count_write = host_sel && host_wr && ack_err && hit_err && halt_bit;
  assign err_count_wdata_rx = host_wdata[15:8];
  assign err_count_wdata_tx = host_wdata[7:0];

  always @(posedge core_clk) begin
    if (rst) begin
      host_rdata <= `CMC_ZERO16;
    end else if (host_sel && !host_wr && ack_mcr) begin
      host_rdata <= module_configuration;
    end else if (host_sel && !host_wr && ack_err) begin
      host_rdata <= {rx_err_count, tx_err_count};
    end else begin
      host_rdata <= `CMC_ZERO16;
    end
  end

  // ==========================================================
  // Wake detection and bus synchronisation
  wire bus_edge = bus_prev && !bus_rx_recessive;
  wire self_wake = wake_armed && bus_edge;

  always @(posedge core_clk) begin
    if (rst) begin
      bus_prev <= 1'b1;
    end else begin
      bus_prev <= bus_rx_recessive;
    end
  end

  assign sync_clear = (state != ST_SYNC);

  cmc_sync_detect u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clear(sync_clear),
    .bit_tick(bit_tick),
    .bus_recessive(bus_rx_recessive),
    .synced(synced)
  );

  // ==========================================================
  // Mode sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stop_bit) begin
          next_state = ST_STOP;
        end else if (debug_req) begin
          next_state = ST_DEBUG;
        end
      end
      ST_DEBUG: begin
        if (stop_bit) begin
          next_state = ST_STOP;
        end else if (!debug_req) begin
          next_state = ST_SYNC;
        end
      end
      ST_STOP: begin
        if (!stop_bit || self_wake) begin
          next_state = debug_req ? ST_DEBUG : ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (stop_bit) begin
          next_state = ST_STOP;
        end else if (debug_req) begin
          next_state = ST_DEBUG;
        end else if (synced) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_DEBUG;
      end
    endcase
  end

  // ==========================================================
  // Configuration register and status flags
  wire [15:0] wr_keep = (module_configuration & `CMC_RO_MASK) | (host_wdata & ~`CMC_RO_MASK);

  always @(posedge core_clk) begin
    if (rst || soft_reset_pulse) begin
      // Bus control, divider and buffers live elsewhere and see no soft reset
      module_configuration <= `CMC_MCR_RESET;
      state <= ST_DEBUG;
      wake_armed <= 1'b0;
    end else begin
      state <= next_state;
      if (mcr_write) begin
        module_configuration <= wr_keep;
        // Self-wake may only change while not stopped; host must read it back
        if (state == ST_STOP) begin
          module_configuration[`CMC_B_SELF_WAKE] <= module_configuration[`CMC_B_SELF_WAKE];
        end
      end
      if (self_wake) begin
        module_configuration[`CMC_B_STOP] <= 1'b0;
      end
      module_configuration[`CMC_B_NOT_SYNCED] <= not_synced;
      module_configuration[`CMC_B_DBG_ENTERED] <= dbg_entered;
      module_configuration[`CMC_B_STOPPED] <= stopped;
      if (next_state == ST_STOP && state != ST_STOP) begin
        wake_armed <= module_configuration[`CMC_B_SELF_WAKE];
      end else if (next_state != ST_STOP) begin
        wake_armed <= 1'b0;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      // Self-clearing: the pulse is gated by its own previous value, so it lasts one cycle
      soft_reset_pulse <= mcr_write && host_wdata[`CMC_B_SOFT_RST] && !soft_reset_pulse;
    end
  end

  always @(posedge core_clk) begin
    if (rst || soft_reset_pulse) begin
      not_synced <= 1'b1;
      dbg_entered <= 1'b0;
      stopped <= 1'b0;
      wake_interrupt <= 1'b0;
    end else begin
      not_synced <= (next_state != ST_RUN);
      if (next_state == ST_DEBUG) begin
        dbg_entered <= 1'b1;
      end else if (prescaler_run) begin
        dbg_entered <= 1'b0;
      end
      stopped <= (state == ST_STOP);
      wake_interrupt <= self_wake && module_configuration[`CMC_B_WAKE_IE];
    end
  end

  // ==========================================================
  // Clock gating
  // Power save only looks at work pending, never the wake bits
  wire psave_idle = module_configuration[`CMC_B_AUTO_PSAVE] && !core_busy;
  assign core_clk_enable = (state != ST_STOP) && !psave_idle;
  assign prescaler_run = (state == ST_SYNC) || (state == ST_RUN);
  assign host_clk_enable = 1'b1;

  // ==========================================================
  // Interrupt arbitration
  assign arbitration_id_out = module_configuration[`CMC_ARB_HI:`CMC_ARB_LO];
  assign arbitration_active = !interrupt_style_select &&
                              (module_configuration[`CMC_ARB_HI:`CMC_ARB_LO] != 4'h0);

endmodule // cmc_module_config
`default_nettype wire

/* File: design/cmc_sync_detect.v */
// Counts consecutive recessive bus bits and flags bus synchronisation.
// Assumes bit_tick marks one bus bit time, bus_recessive sampled synchronously.
`timescale 1ns/100ps
`default_nettype none
`include "cmc_consts.vh"

module cmc_sync_detect #(
  parameter [`CMC_SYNC_W-1:0] SYNC_BITS = `CMC_SYNC_BITS
) (
  input wire core_clk,
  input wire rst,
  input wire clear,
  input wire bit_tick,
  input wire bus_recessive,
  output reg synced
);

  reg [`CMC_SYNC_W-1:0] run_count;

  always @(posedge core_clk) begin
    if (rst || clear) begin
      run_count <= {`CMC_SYNC_W{1'b0}};
      synced <= 1'b0;
    end else if (bit_tick) begin
      if (!bus_recessive) begin
        run_count <= {`CMC_SYNC_W{1'b0}};
      end else if (run_count != SYNC_BITS) begin
        run_count <= run_count + 1'b1;
      end
      // Latches until the owner clears it, which it does once the mode leaves sync
      if (bus_recessive && run_count == SYNC_BITS - 1'b1) begin
        synced <= 1'b1;
      end
    end
  end

endmodule // cmc_sync_detect
`default_nettype wire

/* File: sim/cmc_bus_model.sv */
// Line-side model: bit ticks and the received bus level.
// Assumes the bench commands a dominant level through go_dom.
`timescale 1ns/100ps
`default_nettype none
module cmc_bus_model (
  input wire logic core_clk,
  input wire logic go_dom,
  output logic bit_tick,
  output logic bus_rx_recessive
);
  // ==========================================
  // Bit timing
  logic [1:0] div = 2'h0;
  initial {bit_tick, bus_rx_recessive} = 2'b01;
  always @(posedge core_clk) begin
    div <= div + 2'h1;
    bit_tick <= (div == 2'h3);
    bus_rx_recessive <= !go_dom;
  end
endmodule // cmc_bus_model
`default_nettype wire

/* File: sim/cmc_checker.sv */
// Checker: host acknowledge, pulses and host clock enable.
// Assumes binding onto cmc_module_config.
`timescale 1ns/100ps
`default_nettype none
module cmc_checker #(
  parameter CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic space_code_bit,
  input wire logic slave_acknowledge,
  input wire logic unimplemented_access,
  input wire logic interrupt_style_select,
  input wire logic err_count_write,
  input wire logic soft_reset_pulse,
  input wire logic host_clk_enable,
  input wire logic wake_interrupt,
  input wire logic [3:0] arbitration_id_out,
  input wire logic arbitration_active
);
  // ==========================================
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_user_cfg; host_sel && !space_code_bit && host_addr == 8'h00 |-> !slave_acknowledge; endproperty
  a_user_cfg: assert property (p_user_cfg) else $error("user config access acked");
  property p_sup_ack; host_sel && space_code_bit && host_addr inside {8'h00, 8'h26} |-> slave_acknowledge; endproperty
  a_sup_ack: assert property (p_sup_ack) else $error("supervisor access not acked");
  property p_unimpl; unimplemented_access |-> !slave_acknowledge && !space_code_bit; endproperty
  a_unimpl: assert property (p_unimpl) else $error("bad unimplemented flag");
  property p_err_wr; err_count_write |-> host_sel && host_wr && host_addr == 8'h26 && slave_acknowledge; endproperty
  a_err_wr: assert property (p_err_wr) else $error("counter write without host write");
  property p_srst; soft_reset_pulse |-> $past(host_sel && host_wr && host_addr == 8'h00 && host_wdata[9]); endproperty
  a_srst: assert property (p_srst) else $error("soft reset without request");
  property p_wake_once; wake_interrupt |=> !wake_interrupt; endproperty
  a_wake_once: assert property (p_wake_once) else $error("wake pulse too long");
  property p_host_clk; host_clk_enable; endproperty
  a_host_clk: assert property (p_host_clk) else $error("host clock stopped");
  property p_arb; arbitration_active |-> !interrupt_style_select && arbitration_id_out != 4'h0; endproperty
  a_arb: assert property (p_arb) else $error("arbitration when not allowed");
  c_srst: cover property (soft_reset_pulse);
  c_wake: cover property (wake_interrupt);
  c_err_wr: cover property (err_count_write);
endmodule // cmc_checker
bind cmc_module_config cmc_checker #(.CNT_W(CNT_W)) u_chk (.core_clk, .rst, .host_sel, .host_wr,
  .host_addr, .host_wdata, .space_code_bit, .slave_acknowledge, .unimplemented_access,
  .interrupt_style_select, .err_count_write, .soft_reset_pulse, .host_clk_enable,
  .wake_interrupt, .arbitration_id_out, .arbitration_active);
`default_nettype wire

/* File: sim/test_cmc_module_config.sv */
// Bench for the module configuration block.
// Assumes the line model supplies bit ticks and the bus level.
`timescale 1ns/100ps
`default_nettype none
module test_cmc_module_config;
  logic core_clk = 0, rst = 1, sel = 0, wr = 0, sp = 1, sus = 0, busy = 1, iss = 0, dom = 0;
  logic [7:0] addr = 0, rxc = 0, txc = 0;
  logic [15:0] wd = 0, rdata, m, r;
  logic ack, un, ew, srp, wki, cke, hke, prun, arba, tick, rec, a_s, u_s, e_s;
  logic [3:0] aid, id;
  integer fails = 0, checks_done = 0, cyc = 0, wakes = 0, srsts = 0, i, k;
  always #25 core_clk = ~core_clk;
  cmc_bus_model bus (.core_clk(core_clk), .go_dom(dom), .bit_tick(tick), .bus_rx_recessive(rec));
  cmc_module_config DUT (.core_clk(core_clk), .rst(rst), .host_sel(sel), .host_wr(wr),
    .host_addr(addr), .host_wdata(wd), .space_code_bit(sp), .host_rdata(rdata),
    .slave_acknowledge(ack), .unimplemented_access(un), .debug_suspend(sus),
    .bus_rx_recessive(rec), .bit_tick(tick), .core_busy(busy), .interrupt_style_select(iss),
    .rx_err_count(rxc), .tx_err_count(txc), .err_count_write(ew), .err_count_wdata_rx(),
    .err_count_wdata_tx(), .soft_reset_pulse(srp), .core_clk_enable(cke),
    .host_clk_enable(hke), .prescaler_run(prun), .wake_interrupt(wki),
    .arbitration_id_out(aid), .arbitration_active(arba));
  // ==========================================
  // Monitor and timeout
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    wakes <= wakes + (wki === 1'b1);
    srsts <= srsts + (srp === 1'b1);
    if (cyc == 5000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  // ==========================================
  // Tasks
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic s, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {sel, wr, sp, addr, wd} <= {1'b1, w, s, a, d};
    #1 {a_s, u_s, e_s} = {ack, un, ew};
    @(posedge core_clk);
    sel <= 1'b0;
    #1 r = rdata;
  endtask
  task tick_wait(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  initial begin
    i = $urandom(34763);
    {iss, rxc, txc} <= 17'($urandom);
    tick_wait(6);
    rst <= 1'b0;
    tick_wait(2);
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h5980);
    chk(aid, 0);
    acc(1, 1, 8'h26, 16'($urandom));
    chk(e_s, 1);
    acc(1, 1, 8'h00, 16'h4080);
    acc(1, 1, 8'h26, 16'($urandom));
    chk(e_s, 0);
    acc(0, 1, 8'h26, 0);
    chk(r, {rxc, txc});
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h4880);
    tick_wait(60);
    acc(1, 1, 8'h00, 16'h4990);
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h4080);
    $display("sync test done");
    sus <= 1'b1;
    // Status bits reach the register one cycle after the mode flags
    tick_wait(2);
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h4980);
    acc(1, 1, 8'h00, 16'h2080);
    tick_wait(3);
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h2880);
    tick_wait(60);
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h2080);
    sus <= 1'b0;
    $display("suspend test done");
    for (i = 0; i < 2; i++) begin
      m = {1'b1, 4'h0, i[0], 10'h040};
      acc(1, 1, 8'h00, m & 16'h7fff);
      acc(1, 1, 8'h00, m);
      tick_wait(2);
      chk(cke, 0);
      acc(0, 1, 8'h00, 0);
      chk(r, m | 16'h0810);
      k = wakes;
      dom <= 1'b1;
      tick_wait(4);
      dom <= 1'b0;
      acc(0, 1, 8'h00, 0);
      chk(r & 16'h8010, 0);
      chk(16'(wakes - k), 16'(i));
    end
    $display("stop test done");
    acc(1, 1, 8'h00, 16'h8080);
    acc(1, 1, 8'h00, 16'h8280);
    k = srsts;
    acc(0, 1, 8'h26, 0);
    acc(0, 1, 8'h00, 0);
    chk(r, 16'h5980);
    chk(16'(srsts - k), 1);
    acc(0, 0, 8'h26, 0);
    chk({a_s, u_s}, 0);
    id = 4'($urandom);
    acc(1, 1, 8'h00, {12'h000, id});
    chk(aid, id);
    acc(0, 0, 8'h26, 0);
    chk(a_s, 1);
    acc(0, 0, 8'h00, 0);
    chk({a_s, u_s}, 1);
    $display("access test done");
    acc(1, 1, 8'h00, 16'h0020);
    busy <= 1'b0;
    tick_wait(3);
    chk(cke, 0);
    acc(0, 1, 8'h00, 0);
    chk({hke, a_s}, 3);
    busy <= 1'b1;
    tick_wait(3);
    chk(cke, 1);
    $display("power save test done");
    end_of_test;
  end
endmodule // test_cmc_module_config
`default_nettype wire
